// ### rtl/ctf_pkg.sv
// constants for the transmit-buffer flag and interrupt-enable block
// assumes a 32-bit apb slave port with one aligned word per register
package ctf_pkg;

    // number of transmit message buffers
    localparam int unsigned CTF_NUM_BUF = 3;

    // register byte offsets
    localparam logic [7:0] CTF_OFS_EMPTY_FLAGS = 8'h00;
    localparam logic [7:0] CTF_OFS_IRQ_ENABLES = 8'h04;
    localparam logic [7:0] CTF_OFS_ABORT_REQ   = 8'h08;
    localparam logic [7:0] CTF_OFS_ABORT_ACK   = 8'h0C;
    localparam logic [7:0] CTF_OFS_CONTROL_1   = 8'h10;

    // field positions in the control register
    localparam int unsigned CTF_BIT_LISTEN   = 0;
    localparam int unsigned CTF_BIT_INIT_REQ = 1;
    localparam int unsigned CTF_BIT_INIT_ACK = 2;

    // reset values
    localparam logic [2:0] CTF_RST_EMPTY     = 3'h7;
    localparam logic [2:0] CTF_RST_IRQ_EN    = 3'h0;
    localparam logic [2:0] CTF_RST_ABORT_REQ = 3'h0;
    localparam logic [2:0] CTF_RST_ABORT_ACK = 3'h0;
    localparam logic       CTF_RST_LISTEN    = 1'b0;
    localparam logic       CTF_RST_INIT_REQ  = 1'b0;

    // read value of an unmapped address
    localparam logic [31:0] CTF_RD_UNMAPPED = 32'h0000_0000;

endpackage

// ### rtl/ctf_flag_if.sv
// carrier between the register front end and the flag bank
// assumes both ends share one clock
`timescale 1ns/1ps
interface ctf_flag_if;
    logic [2:0] clear_req;   // host asks to clear empty flags
    logic [2:0] abort_set;   // host asks to abort buffers
    logic [2:0] sent;        // engine: message sent ok
    logic [2:0] aborted;     // engine: abort succeeded
    logic       listen;      // listen mode active
    logic [2:0] empty;       // empty flags
    logic [2:0] abort_req;   // abort request bits
    logic [2:0] abort_ack;   // abort acknowledge bits

    modport bank (
        input  clear_req, abort_set, sent, aborted, listen,
        output empty, abort_req, abort_ack
    );
    modport ctrl (
        output clear_req, abort_set, sent, aborted, listen,
        input  empty, abort_req, abort_ack
    );
endinterface

// ### rtl/ctf_flag_bank.sv
// per-buffer empty, abort request and abort acknowledge state
// assumes strobes are one-cycle pulses on the same clock
`timescale 1ns/1ps
module ctf_flag_bank
    import ctf_pkg::*;
(
    // clock and reset
    input  wire logic core_clk_in,
    input  wire logic rst_n_in,
    // flag carrier
    ctf_flag_if.bank  flg
);

    // whole state of the bank
    typedef struct packed {
        logic [2:0] empty;
        logic [2:0] areq;
        logic [2:0] aack;
    } ctf_bank_s;

    ctf_bank_s st_q;
    ctf_bank_s st_d;
    logic [2:0] clr_ok;      // clears that are allowed
    logic [2:0] hw_set;      // hardware sets of empty flags

    // next-state logic
    always_comb begin
        st_d   = st_q;
        // clears are dropped while listening
        clr_ok = flg.clear_req & {3{~flg.listen}}; // R8
        hw_set = flg.sent | flg.aborted; // R3 R4
        // set wins over a same-cycle clear
        st_d.empty = (st_q.empty & ~clr_ok) | hw_set; // R1 R2
        // abort only meaningful while scheduled; empty-set clears it
        st_d.areq = (st_q.areq | (flg.abort_set & ~st_q.empty)) & ~hw_set; // R7
        // ack cleared by an effective clear, set wins
        st_d.aack = (st_q.aack & ~(clr_ok & ~hw_set)) | flg.aborted; // R6
    end

    // state register
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_q <= '{CTF_RST_EMPTY, CTF_RST_ABORT_REQ, CTF_RST_ABORT_ACK};
        end else begin
            st_q <= st_d;
        end
    end

    assign flg.empty     = st_q.empty;
    assign flg.abort_req = st_q.areq;
    assign flg.abort_ack = st_q.aack;

    // successful send leaves the flag set next cycle
    sent_sets_flag_a: assert property (@(posedge core_clk_in) // R3
        disable iff (!rst_n_in) (flg.sent != 3'h0) |=>
        ((flg.empty & $past(flg.sent)) == $past(flg.sent)))
        else $error("sent buffer not marked empty");

    // flag set takes abort request away
    set_drops_abort_a: assert property (@(posedge core_clk_in) // R7
        disable iff (!rst_n_in) ((flg.sent | flg.aborted) != 3'h0) |=>
        ((flg.abort_req & ($past(flg.sent) | $past(flg.aborted))) == 3'h0))
        else $error("abort request survives empty set");

    // listening never clears a flag
    listen_keeps_flags_a: assert property (@(posedge core_clk_in) // R8
        disable iff (!rst_n_in) flg.listen |=>
        ((~flg.empty & $past(flg.empty)) == 3'h0))
        else $error("flag cleared in listen mode");

endmodule

// ### rtl/ctf_top.sv
// transmit-buffer empty flags, abort bits and irq enables with apb
// assumes a synchronous protocol engine on core_clk_in giving pulses
//
// Overview of operation
// (R1) one empty flag per buffer, bits 2:0
// (R2) host clears flag after loading message
// (R3) successful send sets the empty flag
// (R4) successful abort sets the empty flag
// (R5) enabled set flag holds irq pending
// (R6) clearing flag clears abort acknowledge
// (R7) flag becoming set clears abort request
// (R8) listen mode: no clears, no transmissions
// (R9) block buffer access while message scheduled
// (R10) enables held at reset in init mode
// (R11) enables readable always, writable outside init; writes are taken only with both init bits low
// (R12) enable bit gates empty interrupt request
// (R13) one irq output, or of flag and enable
//
// The register offsets and the APB register port were decided locally.
`timescale 1ns/1ps
module ctf_top
    import ctf_pkg::*;
#(
    parameter int unsigned ADDR_W = 8   // apb address width
) (
    // clock and reset
    input  wire logic              core_clk_in,
    input  wire logic              rstn_in,
    // apb slave
    input  wire logic              psel_in,
    input  wire logic              penable_in,
    input  wire logic              pwrite_in,
    input  wire logic [ADDR_W-1:0] paddr_in,
    input  wire logic [31:0]       pwdata_in,
    input  wire logic [3:0]        pstrb_in,
    output logic                   pready_out,
    output logic [31:0]            prdata_out,
    output logic                   pslverr_out,
    // protocol engine
    input  wire logic [2:0]        tx_sent_in,
    input  wire logic [2:0]        tx_aborted_in,
    output logic [2:0]             tx_pending_out,
    output logic [2:0]             abort_request_out,
    // transmit buffer access arbitration
    input  wire logic [2:0]        buf_access_in,
    output logic [2:0]             buf_grant_out,
    // interrupt and mode status
    output logic                   tx_irq_out,
    output logic                   listen_mode_out,
    output logic                   init_mode_out
);

    // reset synchroniser, release through two flops
    logic [1:0] rst_sync_q;
    logic       rst_n;       // synchronised reset for the rest

    // two-flop release of the reset
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // whole register-side state
    typedef struct packed {
        logic [2:0]  irq_en;     // tx_empty_irq_enable bits
        logic        listen;     // listen mode
        logic        init_req;   // init_mode_request
        logic        init_ack;   // init_mode_acknowledge
        logic [31:0] rdata;      // read data for access phase
        logic        slverr;     // error for access phase
    } ctf_top_s;

    ctf_top_s st_q;
    ctf_top_s st_d;

    // carrier to the flag bank
    ctf_flag_if flg ();

    // apb decode helpers
    logic       setup_ph;    // setup cycle of a transfer
    logic       access_ph;   // access cycle, completes now
    logic       wr_acc;      // write completing this cycle
    logic [7:0] ofs;         // low byte of the address
    logic       in_init;     // init mode, both bits high
    logic       init_idle;   // both init bits low
    logic [2:0] wr_bits;     // low write bits, lane 0

    // true when the address hits a mapped register
    function automatic logic ctf_mapped(input logic [7:0] a);
        return (a == CTF_OFS_EMPTY_FLAGS) || (a == CTF_OFS_IRQ_ENABLES) ||
               (a == CTF_OFS_ABORT_REQ)   || (a == CTF_OFS_ABORT_ACK) ||
               (a == CTF_OFS_CONTROL_1);
    endfunction

    // zero wait states: every access completes in its first cycle
    assign setup_ph  = psel_in & ~penable_in;
    assign access_ph = psel_in & penable_in;
    assign wr_acc    = access_ph & pwrite_in & pstrb_in[0];
    assign ofs       = paddr_in[7:0];
    assign wr_bits   = pwdata_in[2:0];
    assign in_init   = st_q.init_req & st_q.init_ack;
    assign init_idle = ~st_q.init_req & ~st_q.init_ack;

    // strobes into the bank, write-one-to-clear on the flags
    always_comb begin
        flg.clear_req = 3'h0;
        flg.abort_set = 3'h0;
        if (wr_acc && ofs == CTF_OFS_EMPTY_FLAGS) begin
            // host marks loaded buffers as due
            flg.clear_req = wr_bits; // R2
        end else if (wr_acc && ofs == CTF_OFS_ABORT_REQ) begin
            // host requests abort of scheduled buffers
            flg.abort_set = wr_bits;
        end
    end

    // engine events pass straight to the bank
    assign flg.sent    = tx_sent_in;
    assign flg.aborted = tx_aborted_in;
    assign flg.listen  = st_q.listen;

    // next-state logic of the register side
    always_comb begin
        st_d = st_q;
        // acknowledge follows request one cycle later
        st_d.init_ack = st_q.init_req;
        // control register write
        if (wr_acc && ofs == CTF_OFS_CONTROL_1) begin
            st_d.listen   = pwdata_in[CTF_BIT_LISTEN];
            st_d.init_req = pwdata_in[CTF_BIT_INIT_REQ];
        end
        // enables: writable only with both init bits low
        if (wr_acc && ofs == CTF_OFS_IRQ_ENABLES && init_idle) begin
            st_d.irq_en = wr_bits; // R11
        end
        // held in reset state throughout init mode
        if (in_init) begin
            st_d.irq_en = CTF_RST_IRQ_EN; // R10
        end
        // read data captured in setup, shown in access
        if (setup_ph) begin
            st_d.rdata  = CTF_RD_UNMAPPED;
            st_d.slverr = ~ctf_mapped(ofs);
            if (ofs == CTF_OFS_EMPTY_FLAGS) begin
                st_d.rdata[2:0] = flg.empty; // R1
            end else if (ofs == CTF_OFS_IRQ_ENABLES) begin
                // readable at any time, init or not
                st_d.rdata[2:0] = st_q.irq_en; // R11
            end else if (ofs == CTF_OFS_ABORT_REQ) begin
                st_d.rdata[2:0] = flg.abort_req;
            end else if (ofs == CTF_OFS_ABORT_ACK) begin
                st_d.rdata[2:0] = flg.abort_ack;
            end else if (ofs == CTF_OFS_CONTROL_1) begin
                st_d.rdata[CTF_BIT_LISTEN]   = st_q.listen;
                st_d.rdata[CTF_BIT_INIT_REQ] = st_q.init_req;
                st_d.rdata[CTF_BIT_INIT_ACK] = st_q.init_ack;
            end else begin
                // unmapped: zero data and an error
                st_d.rdata = CTF_RD_UNMAPPED;
            end
        end
    end

    // state register of the register side
    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            st_q.irq_en   <= CTF_RST_IRQ_EN;
            st_q.listen   <= CTF_RST_LISTEN;
            st_q.init_req <= CTF_RST_INIT_REQ;
            st_q.init_ack <= CTF_RST_INIT_REQ;
            st_q.rdata    <= CTF_RD_UNMAPPED;
            st_q.slverr   <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    // the flag bank itself
    ctf_flag_bank u_bank (
        .core_clk_in (core_clk_in),
        .rst_n_in    (rst_n),
        .flg         (flg)
    );

    // apb answer, handshake combinational, data from flops
    assign pready_out  = access_ph;
    assign prdata_out  = st_q.rdata;
    assign pslverr_out = access_ph & st_q.slverr;

    // no transmission starts while listening
    assign tx_pending_out    = ~flg.empty & {3{~st_q.listen}}; // R8
    assign abort_request_out = flg.abort_req;

    // scheduled buffers are locked against host access
    assign buf_grant_out = buf_access_in & flg.empty; // R9

    // single irq: any enabled empty flag
    assign tx_irq_out = |(flg.empty & st_q.irq_en); // R5 R12 R13

    // mode status
    assign listen_mode_out = st_q.listen;
    assign init_mode_out   = in_init;

    // checks run on the synchronised reset
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n);

    // a write to the enables in a given init state
    sequence en_write_s;
        wr_acc && (ofs == CTF_OFS_IRQ_ENABLES);
    endsequence

    sequence en_write_idle_s;
        en_write_s ##0 init_idle;
    endsequence

    sequence flag_clear_s;
        wr_acc && (ofs == CTF_OFS_EMPTY_FLAGS) && !st_q.listen &&
        (wr_bits != 3'h0) && ((tx_sent_in | tx_aborted_in) == 3'h0);
    endsequence

    // with both init bits low a write lands one cycle later
    en_write_lands_a: assert property ( // R11
        en_write_idle_s |=> (st_q.irq_en == $past(wr_bits)))
        else $error("enable write lost outside init");

    // during init the enables stay at reset value
    en_held_init_a: assert property ( // R10
        in_init |=> (st_q.irq_en == CTF_RST_IRQ_EN))
        else $error("enables not held during init");

    // partial init state ignores enable writes
    en_write_block_a: assert property ( // R11
        (en_write_s ##0 (!init_idle && !in_init)) |=>
        (st_q.irq_en == $past(st_q.irq_en)) || in_init)
        else $error("enable write taken in init transition");

    // irq tracks flags and enables together
    irq_from_flags_a: assert property ( // R13
        tx_irq_out == ((flg.empty & st_q.irq_en) != 3'h0))
        else $error("irq does not match enabled flags");

    // a set enabled flag of buffer 0 keeps irq high until cleared
    irq_pending_a: assert property ( // R5
        ((flg.empty[0] && st_q.irq_en[0]) [*2]) |-> tx_irq_out)
        else $error("enabled empty flag without irq");

    // with enables zero no irq at all
    irq_masked_a: assert property ( // R12
        (st_q.irq_en == 3'h0) |-> !tx_irq_out)
        else $error("irq while all masked");

    // an effective clear drops the flag and its ack
    clear_drops_ack_a: assert property ( // R6
        flag_clear_s |=>
        ((flg.empty & $past(wr_bits)) == 3'h0) &&
        ((flg.abort_ack & $past(wr_bits)) == 3'h0))
        else $error("clear left flag or ack set");

    // abort success sets the flag and the ack
    abort_sets_flag_a: assert property ( // R4
        (tx_aborted_in != 3'h0) |=>
        ((flg.empty & $past(tx_aborted_in)) == $past(tx_aborted_in)) &&
        ((flg.abort_ack & $past(tx_aborted_in)) == $past(tx_aborted_in)))
        else $error("abort did not set flag and ack");

    // listening never starts a transmission
    listen_no_tx_a: assert property ( // R8
        st_q.listen |-> (tx_pending_out == 3'h0))
        else $error("transmission pending in listen mode");

    // scheduled buffer never granted to the host
    lock_scheduled_a: assert property ( // R9
        ((buf_grant_out & ~flg.empty) == 3'h0))
        else $error("access granted to scheduled buffer");

    // flags read back what the bank holds
    flag_readback_a: assert property ( // R1
        (setup_ph && !pwrite_in && ofs == CTF_OFS_EMPTY_FLAGS) |=>
        (prdata_out == {29'h0, $past(flg.empty)}))
        else $error("flag read data wrong");

    // unmapped access answers with an error
    unmapped_err_a: assert property (
        (setup_ph && !ctf_mapped(ofs)) ##1 access_ph |-> pslverr_out)
        else $error("unmapped access without error");

    // entering init takes two steps: request, then acknowledge
    sequence init_enter_s;
        $rose(st_q.init_req) ##1 (st_q.init_req && st_q.init_ack);
    endsequence

    // a host clear of the flags while listening
    sequence listen_clear_s;
        st_q.listen && wr_acc && (ofs == CTF_OFS_EMPTY_FLAGS);
    endsequence

    // acknowledge trails the request by exactly one cycle
    init_ack_trails_a: assert property ( // R10
        1'b1 |=> (st_q.init_ack == $past(st_q.init_req)))
        else $error("init acknowledge out of step");

    // once init is entered the enables fall to reset value
    init_entry_clears_a: assert property ( // R10
        init_enter_s |=> (st_q.irq_en == CTF_RST_IRQ_EN))
        else $error("enables survive init entry");

    // enables read back what the register holds
    en_readback_a: assert property ( // R11
        (setup_ph && !pwrite_in && ofs == CTF_OFS_IRQ_ENABLES) |=>
        (prdata_out == {29'h0, $past(st_q.irq_en)}))
        else $error("enable read data wrong");

    // abort request bits read back what the bank holds
    areq_readback_a: assert property ( // R7
        (setup_ph && !pwrite_in && ofs == CTF_OFS_ABORT_REQ) |=>
        (prdata_out == {29'h0, $past(flg.abort_req)}))
        else $error("abort request read data wrong");

    // an abort set on an empty buffer is dropped
    abort_on_empty_a: assert property ( // R7
        (wr_acc && ofs == CTF_OFS_ABORT_REQ) |=>
        ((flg.abort_req & ~$past(flg.abort_req) & $past(flg.empty))
        == 3'h0))
        else $error("abort request set on empty buffer");

    // listening: flags move only by engine sets
    listen_refuse_a: assert property ( // R8
        listen_clear_s |=> (flg.empty == ($past(flg.empty) |
        $past(tx_sent_in) | $past(tx_aborted_in))))
        else $error("flag cleared while listening");

    // a sent buffer stops being offered to the engine
    sent_ends_pending_a: assert property ( // R3
        (tx_sent_in != 3'h0) |=>
        ((tx_pending_out & $past(tx_sent_in)) == 3'h0))
        else $error("sent buffer still pending");

    // empty buffers asked for are granted to the host
    grant_empty_a: assert property ( // R9
        ((buf_access_in & flg.empty & ~buf_grant_out) == 3'h0))
        else $error("empty buffer not granted");

endmodule

// ### tb/ctf_engine_model.sv
// behavioural protocol engine: sends or aborts scheduled buffers
// assumes pending and abort request levels from the flag block
`timescale 1ns/1ps
module ctf_engine_model (
    // clock and reset
    input  wire logic       core_clk_in,
    input  wire logic       rstn_in,
    // flag block side
    input  wire logic [2:0] pending_in,
    input  wire logic [2:0] abort_req_in,
    input  wire logic [7:0] delay_in,
    output logic [2:0]      sent_out,
    output logic [2:0]      aborted_out
);
    int cnt [3];  // cycles each buffer has waited
    // a buffer ends delay_in cycles after it became scheduled
    always @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sent_out    <= 3'h0;
            aborted_out <= 3'h0;
            cnt         <= '{0, 0, 0};
        end else begin
            for (int i = 0; i < 3; i++) begin
                sent_out[i]    <= 1'b0;
                aborted_out[i] <= 1'b0;
                // idle buffers never start; a pulse is never repeated
                if (!pending_in[i] || sent_out[i] || aborted_out[i]) begin
                    cnt[i] <= 0;
                end else if (cnt[i] + 1 >= delay_in) begin
                    if (abort_req_in[i])
                        aborted_out[i] <= 1'b1;
                    else
                        sent_out[i] <= 1'b1;
                    cnt[i] <= 0;
                end else begin
                    cnt[i] <= cnt[i] + 1;
                end
            end
        end
    end
endmodule

// ### tb/ctf_top_tb.sv
// self-checking bench for the transmit flag and enable block
// assumes the engine model on the far side and apb at package offsets
`timescale 1ns/1ps
module ctf_top_tb;
    import ctf_pkg::*;
    logic        clk = 1'b0;        // core clock
    logic        rstn;              // reset, low active
    logic        psel, pen, pwr;    // apb request
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic        pready, pslverr;
    logic [2:0]  sent, abrt, pend, areq, acc, grant;
    logic        irq, lsn, ini;
    logic [7:0]  dly;               // engine answer delay
    int          failures = 0;
    int          n_checks = 0;
    // reference model registers
    int m_empty = 7, m_en = 0, m_areq = 0, m_ack = 0;
    int m_lsn = 0, m_ir = 0, m_ia = 0;
    logic [31:0] seed = 32'hb27f_ad08;
    logic [7:0]  offs [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'hfc};

    always #2 clk = ~clk;

    ctf_top #(.ADDR_W(8)) i_ctf_top (
        .core_clk_in(clk), .rstn_in(rstn), .psel_in(psel),
        .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
        .pwdata_in(pwdata), .pstrb_in(4'hf), .pready_out(pready),
        .prdata_out(prdata), .pslverr_out(pslverr), .tx_sent_in(sent),
        .tx_aborted_in(abrt), .tx_pending_out(pend),
        .abort_request_out(areq), .buf_access_in(acc),
        .buf_grant_out(grant), .tx_irq_out(irq),
        .listen_mode_out(lsn), .init_mode_out(ini));

    ctf_engine_model i_ctf_engine_model (
        .core_clk_in(clk), .rstn_in(rstn), .pending_in(pend),
        .abort_req_in(areq), .delay_in(dly), .sent_out(sent),
        .aborted_out(abrt));

    // model follows bus writes, engine pulses and init at each edge
    always @(posedge clk) begin
        int ev, o_ir, o_ia;
        ev   = sent | abrt;
        o_ir = m_ir;
        o_ia = m_ia;
        if (rstn) begin
            if (psel && pen && pwr && pready)
                mwrite(paddr, pwdata, ev);
            m_empty = m_empty | ev;
            m_areq  = m_areq & ~ev;
            m_ack   = m_ack | abrt;
            m_ia    = o_ir;
            if (o_ir && o_ia)
                m_en = 0;
        end
    end

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // model side of a completed write
    task automatic mwrite(input logic [7:0] a, input int d, input int ev);
        case (a)
            CTF_OFS_EMPTY_FLAGS: if (!m_lsn) begin
                m_empty &= ~(d & 7);
                m_ack   &= ~(d & 7 & ~ev);
            end
            CTF_OFS_IRQ_ENABLES: if (!m_ir && !m_ia) m_en = d & 7;
            CTF_OFS_ABORT_REQ: m_areq |= d & 7 & ~m_empty;
            CTF_OFS_CONTROL_1: begin
                m_lsn = d & 1;
                m_ir  = (d >> 1) & 1;
            end
            default: ;
        endcase
    endtask

    function automatic int mval(input logic [7:0] a);
        case (a)
            CTF_OFS_EMPTY_FLAGS: return m_empty;
            CTF_OFS_IRQ_ENABLES: return m_en;
            CTF_OFS_ABORT_REQ:   return m_areq;
            CTF_OFS_ABORT_ACK:   return m_ack;
            CTF_OFS_CONTROL_1:   return m_lsn | (m_ir << 1) | (m_ia << 2);
            default:             return CTF_RD_UNMAPPED;
        endcase
    endfunction

    // one apb transfer, waiting for pready under a bound
    task automatic apb(input logic w, input logic [7:0] a, input int d,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        psel   <= 1'b1;
        pwr    <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1)
            failures++;
        rd  = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen  <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input int d);
        logic [31:0] rd;
        logic        er;
        apb(1'b1, a, d, rd, er);
    endtask

    task automatic rdchk(input logic [7:0] a);
        logic [31:0] rd;
        logic        er;
        apb(1'b0, a, 0, rd, er);
        chk(rd, mval(a));
        chk(32'(er), 32'(a > CTF_OFS_CONTROL_1));
    endtask

    // levels that follow the registers
    task automatic chk_out();
        @(negedge clk);
        chk(32'(pend), ~m_empty & (m_lsn ? 0 : 7));
        chk(32'(grant), acc & m_empty);
        chk(32'(irq), (m_empty & m_en) != 0);
        chk(32'(areq), m_areq);
        @(posedge clk);
    endtask

    // bounded wait until no buffer is scheduled
    task automatic wait_idle();
        int n;
        n = 0;
        while (pend !== 3'h0 && n < 300) begin
            @(posedge clk);
            n++;
        end
        if (n >= 300)
            failures++;
        chk_out();
    endtask

    task automatic conclude();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // watchdog well past the expected run length
    initial begin
        #100000;
        failures++;
        conclude();
    end

    initial begin
        rstn = 1'b0;
        psel = 1'b0;
        pen = 1'b0;
        pwr = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        acc = 3'h0;
        dly = 8'h04;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        // reset values and unmapped offsets
        foreach (offs[i]) rdchk(offs[i]);
        // every enable code, read back
        for (int i = 0; i < 8; i++) begin
            wr(CTF_OFS_IRQ_ENABLES, i);
            rdchk(CTF_OFS_IRQ_ENABLES);
            chk_out();
        end
        // random schedules answered at random speed
        for (int i = 0; i < 24; i++) begin
            dly <= 8'h02 + 8'(xs() & 15);
            acc <= 3'(xs());
            wr(CTF_OFS_IRQ_ENABLES, xs());
            wr(CTF_OFS_EMPTY_FLAGS, xs());
            chk_out();
            wait_idle();
            rdchk(CTF_OFS_EMPTY_FLAGS);
        end
        // abort two buffers, one request falls on an empty buffer
        dly <= 8'h50;
        wr(CTF_OFS_EMPTY_FLAGS, 32'h0000_0005);
        wr(CTF_OFS_ABORT_REQ, 32'h0000_0007);
        rdchk(CTF_OFS_ABORT_REQ);
        chk_out();
        wait_idle();
        rdchk(CTF_OFS_ABORT_ACK);
        rdchk(CTF_OFS_ABORT_REQ);
        wr(CTF_OFS_EMPTY_FLAGS, 32'h0000_0001);
        rdchk(CTF_OFS_ABORT_ACK);
        wait_idle();
        // listen mode refuses clears
        wr(CTF_OFS_CONTROL_1, 32'h0000_0001);
        wr(CTF_OFS_EMPTY_FLAGS, 32'h0000_0007);
        rdchk(CTF_OFS_EMPTY_FLAGS);
        chk_out();
        wr(CTF_OFS_CONTROL_1, 32'h0000_0000);
        // init mode holds enables at reset value
        wr(CTF_OFS_IRQ_ENABLES, 32'h0000_0006);
        wr(CTF_OFS_CONTROL_1, 32'h0000_0002);
        repeat (3) @(posedge clk);
        rdchk(CTF_OFS_IRQ_ENABLES);
        rdchk(CTF_OFS_CONTROL_1);
        wr(CTF_OFS_IRQ_ENABLES, 32'h0000_0005);
        rdchk(CTF_OFS_IRQ_ENABLES);
        chk_out();
        wr(CTF_OFS_CONTROL_1, 32'h0000_0000);
        repeat (3) @(posedge clk);
        wr(CTF_OFS_IRQ_ENABLES, 32'h0000_0005);
        rdchk(CTF_OFS_IRQ_ENABLES);
        chk_out();
        conclude();
    end
endmodule
